/* hdl/tfu_unpacker.sv */
// Texel format unpacker: stored surface words in, sampler channel values out
//
// Contract
// - 11-bit float: exponent in bits 10:6, six-bit fraction in bits 5:0.
// - 10-bit float: exponent in bits 9:5, five-bit fraction in bits 4:0.
// - Small floats unsigned; e=31 NaN/infinity, normal 1.f, e=0 denormal 0.f.
// - Largest finite results are 65024 (11-bit) and 64512 (10-bit).
// - Single-to-half conversion should round to nearest even.
// - Shared exponent: e 31:27, blue 26:18, green 17:9, red 8:0.
// - Shared exponent uses implied zero; no infinity, NaN or negatives.
// - Stored pixels are little-endian, byte n holds pixel bits 7:0.
// - Format channels are placed LSB first in listed order.
// - Intensity is copied to red, green, blue and alpha.
// - Luminance is copied to red, green, blue; alpha separate or default.
// - One-bit format: eight texels per byte, texel k in bit k.
// - Alpha-high nibble palette: alpha 7:4 replicated, index 3:0.
// - Index-high nibble palette: index high nibble, alpha low nibble replicated.
// - Alpha-high byte palette: alpha high byte, low byte indexes RGB entry.
// - Index-high byte palette: index 15:8, alpha 7:0.
// - Index-only palettes look up full ARGB, alpha from palette.
// - Compressed word holds two 4x4 blocks, texels 0-15 then 16-31.
// - Block mode from bits 127:125: 00x high, 010, 011, 1xx.
// - High mode colours at 125:111 and 110:96, 3-bit texel selects.
// - Five-bit channels widen by repeating their three top bits below.
// - High mode table: seven interpolated colours opaque, eighth transparent black.
// - High entry n is ((6-n)*c0 + n*c1 + 3)/6, entry 7 black.
`timescale 1ns/1ns
`default_nettype none
`include "tfu_consts.svh"

module tfu_unpacker #(
	parameter int WORD_W = 128
) (
	// Clock and reset
	input  wire logic                    mclk_i,
	input  wire logic                    rst_n_i,
	// Stored word request
	input  wire logic                    in_valid_i,
	input  wire tfu_pkg::tfu_fmt_t       fmt_i,
	input  wire logic [WORD_W-1:0]       word_i,
	input  wire logic [4:0]              texel_sel_i,
	// Decoded texel
	output var  logic                    out_valid_o,
	output var  logic [15:0]             red_o,
	output var  logic [15:0]             green_o,
	output var  logic [15:0]             blue_o,
	output var  logic [15:0]             alpha_o,
	output var  logic                    chan_float_o,
	// Palette lookup request for the external palette
	output var  logic                    pal_lookup_o,
	output var  logic [7:0]              pal_index_o,
	output var  logic                    pal_alpha_o,
	// Side information
	output var  logic                    mono_filter_o,
	output var  tfu_pkg::tfu_blk_mode_t  blk_mode_o,
	output var  logic                    blk_unsupported_o
);

	// ==========================================================
	// Elaboration checks
	generate
		if (WORD_W != `TFU_BLOCK_BITS) begin : g_bad_width
			$error("tfu_unpacker: WORD_W must equal the compressed block width");
		end
	endgenerate

	// ==========================================================
	// Helper functions

	// Small unsigned float to half: same bias, so the fields map over
	function automatic logic [15:0] small_to_half(input logic [4:0] e, input logic [5:0] f);
		return {1'b0, e, f, 4'h0};
	endfunction : small_to_half

	// Shared-exponent channel to half; 0.f * 2^(e-15) is always exact in half
	function automatic logic [15:0] shared_to_half(input logic [4:0] e, input logic [8:0] f);
		logic [3:0]  msb;
		int          ex;
		logic [18:0] sh;
		msb = 4'h0;
		ex  = 0;
		sh  = 19'h0;
		for (int i = 0; i < `TFU_SE_FRAC_BITS; i++) begin
			if (f[i]) begin
				msb = 4'(i);
			end
		end
		ex = int'(e) + int'(msb) - `TFU_HALF_BIAS_FIX;
		if (f == 9'h0) begin
			return 16'h0000;
		end else if (ex >= 1) begin
			sh = {10'h000, f} << (4'ha - msb);
			return {1'b0, ex[4:0], sh[9:0]};
		end else begin
			sh = {10'h000, f} << e;
			return {6'h00, sh[9:0]};
		end
	endfunction : shared_to_half

	// Widen a five-bit channel to eight bits
	function automatic logic [7:0] widen5(input logic [4:0] c);
		return {c, c[4:2]};
	endfunction : widen5

	// One channel of a high-mode table entry
	function automatic logic [7:0] lerp6(input logic [7:0] c0, input logic [7:0] c1, input logic [2:0] n);
		int sum;
		sum = (`TFU_HI_STEPS - int'(n)) * int'(c0) + int'(n) * int'(c1) + `TFU_HI_ROUND;
		return 8'(sum / `TFU_HI_STEPS);
	endfunction : lerp6

	// ==========================================================
	// Stage 1: capture the request

	logic                    s1_valid_reg;
	tfu_pkg::tfu_fmt_t       s1_fmt_reg;
	logic [WORD_W-1:0]       s1_word_reg;
	logic [4:0]              s1_sel_reg;

	// Request valid pipeline, cleared by reset
	// fixed latency valid
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_valid_reg <= 1'b0;
		end else begin
			s1_valid_reg <= in_valid_i;
		end
	end

	// Request payload, taken every cycle; valid qualifies it
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s1_fmt_reg  <= tfu_pkg::tfu_fmt_float_rg11_b10;
			s1_word_reg <= '0;
			s1_sel_reg  <= 5'h00;
		end else begin
			s1_fmt_reg  <= fmt_i;
			s1_word_reg <= word_i;
			s1_sel_reg  <= texel_sel_i;
		end
	end

	// ==========================================================
	// Stage 2: decode

	logic [31:0]              pix;
	logic [7:0]               c0_r;
	logic [7:0]               c0_g;
	logic [7:0]               c0_b;
	logic [7:0]               c1_r;
	logic [7:0]               c1_g;
	logic [7:0]               c1_b;
	logic [2:0]               hi_idx;
	tfu_pkg::tfu_blk_mode_t   mode;

	logic [15:0]              red_next;
	logic [15:0]              green_next;
	logic [15:0]              blue_next;
	logic [15:0]              alpha_next;
	logic                     float_next;
	logic                     lookup_next;
	logic [7:0]               index_next;
	logic                     pal_alpha_next;
	logic                     mono_next;
	logic                     unsup_next;

	// Low word as a pixel; byte 0 of the word is byte n of memory
	// little-endian pixel
	assign pix = s1_word_reg[31:0];

	// Block mode from the three top bits
	// mode select
	always_comb begin
		if (s1_word_reg[`TFU_MODE_B2]) begin
			mode = tfu_pkg::tfu_mixed_block_mode;
		end else if (!s1_word_reg[`TFU_MODE_B1]) begin
			mode = tfu_pkg::tfu_two_colour_high_mode;
		end else if (s1_word_reg[`TFU_MODE_B0]) begin
			mode = tfu_pkg::tfu_alpha_block_mode;
		end else begin
			mode = tfu_pkg::tfu_four_colour_direct_mode;
		end
	end

	// High-mode base colours, widened
	// colour fields
	assign c1_r = widen5(s1_word_reg[`TFU_HI_C1_HI -: 5]);
	assign c1_g = widen5(s1_word_reg[`TFU_HI_C1_HI - 5 -: 5]);
	assign c1_b = widen5(s1_word_reg[`TFU_HI_C1_LO +: 5]);
	assign c0_r = widen5(s1_word_reg[`TFU_HI_C0_HI -: 5]);
	assign c0_g = widen5(s1_word_reg[`TFU_HI_C0_HI - 5 -: 5]);
	assign c0_b = widen5(s1_word_reg[`TFU_HI_C0_LO +: 5]);

	// Texel select; texels 0-15 are the first block, 16-31 the second
	// texel order
	assign hi_idx = s1_word_reg[s1_sel_reg * `TFU_HI_SEL_W +: `TFU_HI_SEL_W];

	// Format decode; all channels default to zero
	always_comb begin
		red_next       = 16'h0000;
		green_next     = 16'h0000;
		blue_next      = 16'h0000;
		alpha_next     = 16'h0000;
		float_next     = 1'b0;
		lookup_next    = 1'b0;
		index_next     = 8'h00;
		pal_alpha_next = 1'b0;
		mono_next      = 1'b0;
		unsup_next     = 1'b0;
		case (s1_fmt_reg)
			tfu_pkg::tfu_fmt_float_rg11_b10: begin
				float_next = 1'b1;
				red_next   = small_to_half(pix[`TFU_F11_RED_LO + `TFU_F11_EXP_LO +: 5],
				                           pix[`TFU_F11_RED_LO +: `TFU_F11_FRAC_HI + 1]);
				green_next = small_to_half(pix[`TFU_F11_GREEN_LO + `TFU_F11_EXP_LO +: 5],
				                           pix[`TFU_F11_GREEN_LO +: `TFU_F11_FRAC_HI + 1]);
				blue_next  = small_to_half(pix[`TFU_F10_BLUE_LO + `TFU_F10_EXP_LO +: 5],
				                           {pix[`TFU_F10_BLUE_LO +: `TFU_F10_FRAC_HI + 1], 1'b0});
				alpha_next = `TFU_HALF_ONE;
			end
			tfu_pkg::tfu_fmt_shared_exponent_rgb: begin
				float_next = 1'b1;
				red_next   = shared_to_half(pix[`TFU_SE_EXP_HI:`TFU_SE_EXP_LO], pix[`TFU_SE_RED_HI:`TFU_SE_RED_LO]);
				green_next = shared_to_half(pix[`TFU_SE_EXP_HI:`TFU_SE_EXP_LO],
				                            pix[`TFU_SE_GREEN_HI:`TFU_SE_GREEN_LO]);
				blue_next  = shared_to_half(pix[`TFU_SE_EXP_HI:`TFU_SE_EXP_LO], pix[`TFU_SE_BLUE_HI:`TFU_SE_BLUE_LO]);
				alpha_next = `TFU_HALF_ONE;
			end
			tfu_pkg::tfu_fmt_intensity8: begin
				red_next   = {8'h00, pix[7:0]};
				green_next = {8'h00, pix[7:0]};
				blue_next  = {8'h00, pix[7:0]};
				alpha_next = {8'h00, pix[7:0]};
			end
			tfu_pkg::tfu_fmt_luminance8: begin
				red_next   = {8'h00, pix[7:0]};
				green_next = {8'h00, pix[7:0]};
				blue_next  = {8'h00, pix[7:0]};
				alpha_next = `TFU_UNORM_ONE;
			end
			tfu_pkg::tfu_fmt_luminance8_alpha8: begin
				red_next   = {8'h00, pix[7:0]};
				green_next = {8'h00, pix[7:0]};
				blue_next  = {8'h00, pix[7:0]};
				alpha_next = {8'h00, pix[15:8]};
			end
			tfu_pkg::tfu_fmt_one_bit_texel_format,
			tfu_pkg::tfu_fmt_mono_filter_bit_format: begin
				red_next   = {8'h00, {8{pix[s1_sel_reg]}}};
				green_next = {8'h00, {8{pix[s1_sel_reg]}}};
				blue_next  = {8'h00, {8{pix[s1_sel_reg]}}};
				alpha_next = {8'h00, {8{pix[s1_sel_reg]}}};
				mono_next  = (s1_fmt_reg == tfu_pkg::tfu_fmt_mono_filter_bit_format);
			end
			tfu_pkg::tfu_fmt_alpha_high_nibble_palette: begin
				lookup_next = 1'b1;
				index_next  = {4'h0, pix[3:0]};
				alpha_next  = {8'h00, pix[7:4], pix[7:4]};
			end
			tfu_pkg::tfu_fmt_index_high_nibble_palette: begin
				lookup_next = 1'b1;
				index_next  = {4'h0, pix[7:4]};
				alpha_next  = {8'h00, pix[3:0], pix[3:0]};
			end
			tfu_pkg::tfu_fmt_alpha_high_byte_palette: begin
				lookup_next = 1'b1;
				index_next  = pix[7:0];
				alpha_next  = {8'h00, pix[15:8]};
			end
			tfu_pkg::tfu_fmt_index_high_byte_palette: begin
				lookup_next = 1'b1;
				index_next  = pix[15:8];
				alpha_next  = {8'h00, pix[7:0]};
			end
			tfu_pkg::tfu_fmt_byte_index_palette: begin
				lookup_next    = 1'b1;
				index_next     = pix[7:0];
				pal_alpha_next = 1'b1;
			end
			tfu_pkg::tfu_fmt_two_bit_index_palette: begin
				lookup_next    = 1'b1;
				index_next     = {6'h00, pix[1:0]};
				pal_alpha_next = 1'b1;
			end
			// Only the two-colour high mode decodes; others flag unsupported
			tfu_pkg::tfu_fmt_compressed_block: begin
				if (mode == tfu_pkg::tfu_two_colour_high_mode) begin
					if (hi_idx != `TFU_HI_BLACK_IDX) begin
						red_next   = {8'h00, lerp6(c0_r, c1_r, hi_idx)};
						green_next = {8'h00, lerp6(c0_g, c1_g, hi_idx)};
						blue_next  = {8'h00, lerp6(c0_b, c1_b, hi_idx)};
						alpha_next = `TFU_UNORM_ONE;
					end
				end else begin
					unsup_next = 1'b1;
				end
			end
			default: begin
				unsup_next = 1'b1;
			end
		endcase
	end

	// ==========================================================
	// Stage 2 output registers

	// Output valid, cleared by reset
	// fixed latency valid
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			out_valid_o <= 1'b0;
		end else begin
			out_valid_o <= s1_valid_reg;
		end
	end

	// Channel data; updated every cycle, so only valid cycles mean anything
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			red_o        <= 16'h0000;
			green_o      <= 16'h0000;
			blue_o       <= 16'h0000;
			alpha_o      <= 16'h0000;
			chan_float_o <= 1'b0;
		end else begin
			red_o        <= red_next;
			green_o      <= green_next;
			blue_o       <= blue_next;
			alpha_o      <= alpha_next;
			chan_float_o <= float_next;
		end
	end

	// Palette request and side flags
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pal_lookup_o      <= 1'b0;
			pal_index_o       <= 8'h00;
			pal_alpha_o       <= 1'b0;
			mono_filter_o     <= 1'b0;
			blk_mode_o        <= tfu_pkg::tfu_two_colour_high_mode;
			blk_unsupported_o <= 1'b0;
		end else begin
			pal_lookup_o      <= lookup_next;
			pal_index_o       <= index_next;
			pal_alpha_o       <= pal_alpha_next;
			mono_filter_o     <= mono_next;
			blk_mode_o        <= mode;
			blk_unsupported_o <= unsup_next;
		end
	end

endmodule : tfu_unpacker
`default_nettype wire

/* common/tfu_consts.svh */
// Bit positions, widths and constant values for the texel format unpacker
`ifndef TFU_CONSTS_SVH
`define TFU_CONSTS_SVH

// ==========================================================
// Small floats: 11-bit and 10-bit, no sign
`define TFU_F11_EXP_HI      10
`define TFU_F11_EXP_LO      6
`define TFU_F11_FRAC_HI     5
`define TFU_F10_EXP_HI      9
`define TFU_F10_EXP_LO      5
`define TFU_F10_FRAC_HI     4
`define TFU_F11_RED_LO      0
`define TFU_F11_GREEN_LO    11
`define TFU_F10_BLUE_LO     22

// ==========================================================
// Shared exponent RGB word
`define TFU_SE_EXP_HI       31
`define TFU_SE_EXP_LO       27
`define TFU_SE_BLUE_HI      26
`define TFU_SE_BLUE_LO      18
`define TFU_SE_GREEN_HI     17
`define TFU_SE_GREEN_LO     9
`define TFU_SE_RED_HI       8
`define TFU_SE_RED_LO       0
`define TFU_SE_FRAC_BITS    9

// ==========================================================
// Compressed two-block word
`define TFU_BLOCK_BITS      128
`define TFU_MODE_B2         127
`define TFU_MODE_B1         126
`define TFU_MODE_B0         125
`define TFU_HI_C1_HI        125
`define TFU_HI_C1_LO        111
`define TFU_HI_C0_HI        110
`define TFU_HI_C0_LO        96
`define TFU_HI_SEL_W        3
`define TFU_HI_BLACK_IDX    3'h7
`define TFU_HI_STEPS        6
`define TFU_HI_ROUND        3

// ==========================================================
// Output encodings
`define TFU_HALF_ONE        16'h3c00
`define TFU_UNORM_ONE       16'h00ff
`define TFU_HALF_BIAS_FIX   9

`endif

/* common/tfu_pkg.sv */
// Types shared by the texel format unpacker and its bench
`default_nettype none
package tfu_pkg;

	// Source surface formats accepted by the unpacker
	typedef enum logic [3:0] {
		tfu_fmt_float_rg11_b10,
		tfu_fmt_shared_exponent_rgb,
		tfu_fmt_intensity8,
		tfu_fmt_luminance8,
		tfu_fmt_luminance8_alpha8,
		tfu_fmt_one_bit_texel_format,
		tfu_fmt_mono_filter_bit_format,
		tfu_fmt_alpha_high_nibble_palette,
		tfu_fmt_index_high_nibble_palette,
		tfu_fmt_alpha_high_byte_palette,
		tfu_fmt_index_high_byte_palette,
		tfu_fmt_byte_index_palette,
		tfu_fmt_two_bit_index_palette,
		tfu_fmt_compressed_block
	} tfu_fmt_t;

	// Compressed block modes
	typedef enum logic [1:0] {
		tfu_two_colour_high_mode,
		tfu_four_colour_direct_mode,
		tfu_alpha_block_mode,
		tfu_mixed_block_mode
	} tfu_blk_mode_t;

endpackage : tfu_pkg
`default_nettype wire

/* tb/tfu_unpacker_monitor.sv */
// Port-level checker for the texel format unpacker
`timescale 1ns/1ns
`default_nettype none
module tfu_unpacker_monitor #(
	parameter int WORD_W = 128
) (
	// Clock and reset
	input wire logic                   mclk_i,
	input wire logic                   rst_n_i,
	// Request
	input wire logic                   in_valid_i,
	input wire tfu_pkg::tfu_fmt_t      fmt_i,
	input wire logic [WORD_W-1:0]      word_i,
	input wire logic [4:0]             texel_sel_i,
	// Result
	input wire logic                   out_valid_o,
	input wire logic [15:0]            red_o,
	input wire logic [15:0]            green_o,
	input wire logic [15:0]            blue_o,
	input wire logic [15:0]            alpha_o,
	input wire logic                   chan_float_o,
	input wire logic                   pal_lookup_o,
	input wire logic [7:0]             pal_index_o,
	input wire logic                   pal_alpha_o,
	input wire logic                   mono_filter_o,
	input wire tfu_pkg::tfu_blk_mode_t blk_mode_o,
	input wire logic                   blk_unsupported_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	// ==========================================================
	// Pipeline timing
	a_valid_two_late: assert property (in_valid_i |-> ##2 out_valid_o) else $error("result not two cycles late");
	a_no_orphan_valid: assert property (out_valid_o |-> $past(in_valid_i, 2)) else $error("result without request");
	// ==========================================================
	// Format decode
	a_float_flag_set: assert property (out_valid_o && $past(fmt_i, 2) == tfu_pkg::tfu_fmt_float_rg11_b10
		|-> chan_float_o) else $error("small float not flagged");
	a_shared_no_inf: assert property (out_valid_o && $past(fmt_i, 2) == tfu_pkg::tfu_fmt_shared_exponent_rgb
		|-> !red_o[15] && red_o[14:10] != 5'h1f) else $error("shared exponent sign or inf");
	a_intensity_all_four: assert property (out_valid_o && $past(fmt_i, 2) == tfu_pkg::tfu_fmt_intensity8
		|-> red_o == green_o && blue_o == alpha_o && red_o == alpha_o) else $error("intensity not copied");
	a_lum_three_copies: assert property (out_valid_o && $past(fmt_i, 2) == tfu_pkg::tfu_fmt_luminance8
		|-> red_o == green_o && green_o == blue_o) else $error("luminance not copied");
	a_bit_texel_pick: assert property (out_valid_o && $past(fmt_i, 2) == tfu_pkg::tfu_fmt_one_bit_texel_format
		|-> red_o == ($past(word_i[texel_sel_i], 2) ? 16'h00ff : 16'h0000)) else $error("bit texel wrong");
	a_byte_pal_split: assert property (out_valid_o && $past(fmt_i, 2) == tfu_pkg::tfu_fmt_index_high_byte_palette
		|-> pal_index_o == $past(word_i[15:8], 2) && alpha_o[7:0] == $past(word_i[7:0], 2))
		else $error("byte palette split wrong");
	a_high_mode_pick: assert property (out_valid_o && $past(fmt_i, 2) == tfu_pkg::tfu_fmt_compressed_block
		&& $past(word_i[127:126], 2) == 2'h0 |-> blk_mode_o == tfu_pkg::tfu_two_colour_high_mode
		&& !blk_unsupported_o) else $error("high mode not selected");
	a_high_black_entry: assert property (out_valid_o && $past(fmt_i, 2) == tfu_pkg::tfu_fmt_compressed_block
		&& $past(word_i[127:126], 2) == 2'h0 && $past(word_i[texel_sel_i * 3 +: 3], 2) == 3'h7
		|-> {red_o, green_o, blue_o, alpha_o} == 64'h0) else $error("entry seven not black");
endmodule : tfu_unpacker_monitor

bind tfu_unpacker tfu_unpacker_monitor #(.WORD_W(WORD_W)) mon_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
	.in_valid_i(in_valid_i), .fmt_i(fmt_i), .word_i(word_i), .texel_sel_i(texel_sel_i),
	.out_valid_o(out_valid_o), .red_o(red_o), .green_o(green_o), .blue_o(blue_o), .alpha_o(alpha_o),
	.chan_float_o(chan_float_o), .pal_lookup_o(pal_lookup_o), .pal_index_o(pal_index_o),
	.pal_alpha_o(pal_alpha_o), .mono_filter_o(mono_filter_o), .blk_mode_o(blk_mode_o),
	.blk_unsupported_o(blk_unsupported_o));
`default_nettype wire

/* tb/tfu_filter_model.sv */
// Filter stage model: latches each decoded texel as it arrives
`timescale 1ns/1ns
`default_nettype none
module tfu_filter_model (
	// Clock and reset
	input  wire logic        mclk_i,
	input  wire logic        rst_n_i,
	// Texel from the unpacker
	input  wire logic        valid_i,
	input  wire logic [63:0] tex_i,
	input  wire logic [7:0]  idx_i,
	input  wire logic [6:0]  flg_i,
	// Captured texel
	output var  logic [63:0] tex_o,
	output var  logic [7:0]  idx_o,
	output var  logic [6:0]  flg_o,
	output var  logic [7:0]  cnt_o
);
	// No back-pressure exists, so every valid cycle must be taken
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tex_o <= 64'h0;
			idx_o <= 8'h0;
			flg_o <= 7'h0;
			cnt_o <= 8'h0;
		end else if (valid_i) begin
			tex_o <= tex_i;
			idx_o <= idx_i;
			flg_o <= flg_i;
			cnt_o <= cnt_o + 8'h1;
		end
	end
endmodule : tfu_filter_model
`default_nettype wire

/* tb/tb_texel_format_unpacker.sv */
// Self-checking bench for the texel format unpacker
`timescale 1ns/1ns
`default_nettype none
module tb_texel_format_unpacker;
	// ==========================================================
	// Stimulus and observation
	logic                   mclk_i      = 1'b0;
	logic                   rst_n_i     = 1'b0;
	logic                   in_valid_i  = 1'b0;
	tfu_pkg::tfu_fmt_t      fmt_i       = tfu_pkg::tfu_fmt_float_rg11_b10;
	logic [127:0]           word_i      = 128'h0;
	logic [4:0]             texel_sel_i = 5'h0;
	logic                   out_valid_o;
	logic [15:0]            red_o, green_o, blue_o, alpha_o;
	logic                   chan_float_o, pal_lookup_o, pal_alpha_o, mono_filter_o, blk_unsupported_o;
	logic [7:0]             pal_index_o;
	tfu_pkg::tfu_blk_mode_t blk_mode_o;
	logic [63:0]            tex;
	logic [7:0]             idx, cnt;
	logic [6:0]             flg;
	int                     fails = 0;
	int                     n_tests = 0;

	// Free-running clock
	always #2 mclk_i = ~mclk_i;

	tfu_unpacker #(.WORD_W(128)) dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .in_valid_i(in_valid_i),
		.fmt_i(fmt_i), .word_i(word_i), .texel_sel_i(texel_sel_i), .out_valid_o(out_valid_o),
		.red_o(red_o), .green_o(green_o), .blue_o(blue_o), .alpha_o(alpha_o), .chan_float_o(chan_float_o),
		.pal_lookup_o(pal_lookup_o), .pal_index_o(pal_index_o), .pal_alpha_o(pal_alpha_o),
		.mono_filter_o(mono_filter_o), .blk_mode_o(blk_mode_o), .blk_unsupported_o(blk_unsupported_o));
	tfu_filter_model filt_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .valid_i(out_valid_o),
		.tex_i({alpha_o, blue_o, green_o, red_o}), .idx_i(pal_index_o),
		.flg_i({blk_unsupported_o, blk_mode_o, mono_filter_o, pal_alpha_o, pal_lookup_o, chan_float_o}),
		.tex_o(tex), .idx_o(idx), .flg_o(flg), .cnt_o(cnt));

	// ==========================================================
	// Shared tasks
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : tally_and_finish

	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// One-cycle request, then a bounded wait for the filter to latch it
	task automatic send(input tfu_pkg::tfu_fmt_t f, input logic [127:0] w, input logic [4:0] s);
		logic [7:0] old;
		old = cnt;
		@(posedge mclk_i);
		in_valid_i <= 1'b1;
		fmt_i <= f;
		word_i <= w;
		texel_sel_i <= s;
		@(posedge mclk_i);
		in_valid_i <= 1'b0;
		for (int i = 0; i < 8 && cnt === old; i++) begin
			@(posedge mclk_i);
			#1;
		end
		if (cnt === old) begin
			chk("result arrival", 64'h0, 64'h1);
			tally_and_finish();
		end
	endtask : send

	// Interpolated high mode channel
	function automatic logic [15:0] mix(input int n, input int a, input int b);
		mix = 16'(((6 - n) * a + n * b + 3) / 6);
	endfunction : mix

	// ==========================================================
	// Scenarios
	task automatic t_floats();
		// Max finite, infinity and max 10-bit; then denormal, NaN and zero
		send(tfu_pkg::tfu_fmt_float_rg11_b10, {96'h0, 10'h3df, 11'h7c0, 11'h7bf}, 5'h0);
		chk("float max inf", tex, {16'h3c00, 16'h7be0, 16'h7c00, 16'h7bf0});
		chk("float flag", flg[0], 64'h1);
		send(tfu_pkg::tfu_fmt_float_rg11_b10, {96'h0, 10'h000, 11'h7c1, 11'h001}, 5'h0);
		chk("float denorm nan", tex, {16'h3c00, 16'h0000, 16'h7c10, 16'h0010});
		send(tfu_pkg::tfu_fmt_shared_exponent_rgb, {96'h0, 5'h0f, 9'h1ff, 9'h000, 9'h100}, 5'h0);
		chk("shared rgb", tex[47:0], {16'h3bfc, 16'h0000, 16'h3800});
		$display("floats done");
	endtask : t_floats

	task automatic t_lum();
		send(tfu_pkg::tfu_fmt_intensity8, 128'h5a, 5'h0);
		chk("intensity", tex, 64'h005a_005a_005a_005a);
		send(tfu_pkg::tfu_fmt_luminance8, 128'h33, 5'h0);
		chk("lum default", tex, 64'h00ff_0033_0033_0033);
		send(tfu_pkg::tfu_fmt_luminance8_alpha8, 128'h9c33, 5'h0);
		chk("lum alpha", tex, 64'h009c_0033_0033_0033);
		$display("lum done");
	endtask : t_lum

	task automatic t_bits();
		logic [4:0] s[3] = '{5'h00, 5'h01, 5'h1f};
		for (int i = 0; i < 3; i++) begin
			send(tfu_pkg::tfu_fmt_one_bit_texel_format, 128'h8000_0001, s[i]);
			chk("bit texel", tex, (i == 1) ? 64'h0 : 64'h00ff_00ff_00ff_00ff);
		end
		send(tfu_pkg::tfu_fmt_mono_filter_bit_format, 128'h8000_0001, 5'h1f);
		chk("mono flag", flg[3], 64'h1);
		$display("bits done");
	endtask : t_bits

	task automatic t_palette();
		tfu_pkg::tfu_fmt_t pf[6] = '{tfu_pkg::tfu_fmt_alpha_high_nibble_palette,
			tfu_pkg::tfu_fmt_index_high_nibble_palette, tfu_pkg::tfu_fmt_alpha_high_byte_palette,
			tfu_pkg::tfu_fmt_index_high_byte_palette, tfu_pkg::tfu_fmt_byte_index_palette,
			tfu_pkg::tfu_fmt_two_bit_index_palette};
		logic [7:0] pi[6] = '{8'h03, 8'h0c, 8'hc3, 8'ha5, 8'hc3, 8'h03};
		logic [7:0] pa[6] = '{8'hcc, 8'h33, 8'ha5, 8'hc3, 8'h00, 8'h00};
		for (int i = 0; i < 6; i++) begin
			send(pf[i], 128'ha5c3, 5'h0);
			chk("pal index", idx, pi[i]);
			chk("pal alpha", tex, {8'h00, pa[i], 48'h0});
			chk("pal flags", flg[2:1], {i > 3, 1'b1});
		end
		$display("palette done");
	endtask : t_palette

	task automatic t_high();
		logic [127:0] w;
		int           sl;
		logic [63:0]  e;
		// Mode 001: bit 125 doubles as colour 1 red MSB; 8 widens to 42h, 16 to 84h
		w = {3'h1, 4'hf, 5'h00, 5'h10, 5'h00, 5'h1f, 5'h08, 96'h0};
		for (int k = 0; k < 32; k++) w[3 * k +: 3] = 3'(k);
		for (int k = 0; k < 32; k++) begin
			sl = k % 8;
			send(tfu_pkg::tfu_fmt_compressed_block, w, 5'(k));
			e = {16'h00ff, mix(sl, 8'h42, 8'h84), mix(sl, 8'hff, 0), mix(sl, 0, 8'hff)};
			chk("high texel", tex, (sl == 7) ? 64'h0 : e);
			chk("high mode", flg[6:4], 64'h0);
		end
		$display("high mode done");
	endtask : t_high

	task automatic t_modes();
		logic [2:0] mb[3] = '{3'h2, 3'h3, 3'h4};
		for (int i = 0; i < 3; i++) begin
			send(tfu_pkg::tfu_fmt_compressed_block, {mb[i], 125'h0}, 5'h0);
			chk("other mode", flg[6:4], {1'b1, 2'(i + 1)});
			chk("other mode zero", tex, 64'h0);
		end
		// Undefined format code answers as unsupported with zero channels
		send(tfu_pkg::tfu_fmt_t'(4'he), 128'hffff_ffff, 5'h0);
		chk("bad format flag", flg[6], 64'h1);
		chk("bad format zero", tex, 64'h0);
		$display("modes done");
	endtask : t_modes

	task automatic t_reset();
		@(posedge mclk_i);
		in_valid_i <= 1'b1;
		@(posedge mclk_i);
		in_valid_i <= 1'b0;
		rst_n_i <= 1'b0;
		repeat (3) @(posedge mclk_i);
		chk("valid in reset", out_valid_o, 64'h0);
		rst_n_i <= 1'b1;
		$display("reset done");
	endtask : t_reset

	// ==========================================================
	// Main sequence
	initial begin
		repeat (8) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		t_floats();
		t_lum();
		t_bits();
		t_palette();
		t_high();
		t_modes();
		t_reset();
		t_lum();
		tally_and_finish();
	end
endmodule : tb_texel_format_unpacker
`default_nettype wire
